//--- rtl/acs_pkg.sv
`default_nettype none

package acs_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ABE       = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;

  // converter_control fields.
  localparam int CTL_ON      = 0;
  localparam int CTL_GO      = 1;
  localparam int CTL_SEL_LSB = 2;
  localparam int CTL_SEL_MSB = 6;

  // analog_block_enable_reg fields.
  localparam int ABE_ANA      = 0;
  localparam int ABE_DSEL_LSB = 4;
  localparam int ABE_DSEL_MSB = 6;
  localparam int ABE_DIG      = 7;

  // Interrupt status and mask fields.
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_W       = 2;

  // Status register fields.
  localparam int ST_BUSY    = 0;
  localparam int ST_VALID   = 1;
  localparam int ST_ANA_PIN = 2;
  localparam int ST_DIG_PIN = 3;

  // Reset values.
  localparam logic [4:0]        SEL_RST  = 5'h00;
  localparam logic [2:0]        DSEL_RST = 3'h0;
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 2'h0;

  // Channel selector code boundaries.
  localparam logic [4:0] CH_INT_LAST   = 5'h07;
  localparam logic [4:0] CH_INT2_FIRST = 5'h0A;
  localparam logic [4:0] CH_INT2_LAST  = 5'h10;
  localparam logic [4:0] CH_PIN_FIRST  = 5'h18;
  localparam logic [4:0] CH_PIN_LAST   = 5'h1C;
  localparam logic [4:0] CH_BIG_FIRST  = 5'h1D;

  // AHB-Lite encodings.
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam int         HTRANS_ACT = 1;

  typedef enum logic [1:0] {
    ACS_IDLE  = 2'b00,
    ACS_START = 2'b01,
    ACS_BUSY  = 2'b11
  } acs_state_t;

endpackage : acs_pkg

`default_nettype wire

//--- rtl/acs_top.sv
// Overview of operation
// RULE1 - Control register holds the five-bit channel selector in bits six to two.
// RULE2 - Codes 00000 to 00111 route the eight first internal analog nodes.
// RULE3 - Codes 01010 to 10000 route more nodes; 01000, 01001, 10001-10111 none.
// RULE4 - Codes 11000 to 11100 route pins; 11101 to 11111 larger package only.
// RULE5 - Writing one to go bit one starts a conversion; reads one meanwhile.
// RULE6 - Hardware clears go on completion; zero means nothing in progress.
// RULE7 - Enable bit zero powers the converter; clear shuts it off.
// RULE8 - The selector also picks the signal at the test pin buffer.
// RULE9 - Bit seven is unimplemented: writes ignored, reads zero.
// RULE10 - With analog test route clear, selected signals go to the converter.
// RULE11 - Digital test route wins the test pin over the analog route.
// RULE12 - Software enables and settles the selector before go, keeps it meanwhile.
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`default_nettype none

module acs_top #(
  parameter bit LARGE_PKG = 1'b0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        adc_done,
  output logic             converter_on,
  output logic             conv_start,
  output logic      [4:0]  amux_sel,
  output logic             amux_sel_valid,
  output logic             amux_to_adc,
  output logic             amux_to_pin,
  output logic             dmux_to_pin,
  output logic      [2:0]  dmux_sel,
  output logic             irq
);
  import acs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  // True when the access carries byte lane zero, where all fields live.
  function automatic logic lane0(input logic [2:0] size,
                                 input logic [1:0] a);
    logic r;
    r = 1'b1;
    if (size == HSIZE_BYTE) begin
      r = (a == 2'b00);
    end else if (size == HSIZE_HALF) begin
      r = ~a[1];
    end
    return r;
  endfunction : lane0

  // Selector codes that lead to an existing analog source.
  function automatic logic chan_valid(input logic [4:0] c);
    logic r;
    r = 1'b0;
    if (c <= CH_INT_LAST) begin
      r = 1'b1; // RULE2
    end else if (c >= CH_INT2_FIRST && c <= CH_INT2_LAST) begin
      r = 1'b1; // RULE3
    end else if (c >= CH_PIN_FIRST && c <= CH_PIN_LAST) begin
      r = 1'b1; // RULE4
    end else if (c >= CH_BIG_FIRST) begin
      r = LARGE_PKG; // RULE4
    end
    return r;
  endfunction : chan_valid

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture.

  logic       wr_pend_reg, wr_pend_next;
  logic [7:0] waddr_reg, waddr_next;
  logic       wlane_reg, wlane_next;
  logic       take;

  assign take = hsel & hready & htrans[HTRANS_ACT];

  always_comb begin
    wr_pend_next = take & hwrite;
    waddr_next   = waddr_reg;
    wlane_next   = wlane_reg;
    if (take) begin
      waddr_next = haddr[7:0];
      wlane_next = lane0(hsize, haddr[1:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      waddr_reg   <= waddr_next;
      wlane_reg   <= wlane_next;
    end
  end

  logic       wr_ctrl, wr_abe, wr_stat, wr_mask;
  logic [7:0] wb;

  assign wb      = hwdata[7:0];
  assign wr_ctrl = wr_pend_reg & wlane_reg & (waddr_reg == OFS_CTRL);
  assign wr_abe  = wr_pend_reg & wlane_reg & (waddr_reg == OFS_ABE);
  assign wr_stat = wr_pend_reg & wlane_reg & (waddr_reg == OFS_IRQ_STAT);
  assign wr_mask = wr_pend_reg & wlane_reg & (waddr_reg == OFS_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic       on_reg, on_next;
  logic [4:0] sel_reg, sel_next;
  logic       ana_reg, ana_next;
  logic       dig_reg, dig_next;
  logic [2:0] dsel_reg, dsel_next;

  always_comb begin
    on_next   = on_reg;
    sel_next  = sel_reg;
    ana_next  = ana_reg;
    dig_next  = dig_reg;
    dsel_next = dsel_reg;
    if (wr_ctrl) begin
      on_next  = wb[CTL_ON]; // RULE7
      sel_next = wb[CTL_SEL_MSB:CTL_SEL_LSB]; // RULE1
    end
    if (wr_abe) begin
      ana_next  = wb[ABE_ANA];
      dig_next  = wb[ABE_DIG];
      dsel_next = wb[ABE_DSEL_MSB:ABE_DSEL_LSB];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_reg   <= 1'b0;
      sel_reg  <= SEL_RST;
      ana_reg  <= 1'b0;
      dig_reg  <= 1'b0;
      dsel_reg <= DSEL_RST;
    end else begin
      on_reg   <= on_next;
      sel_reg  <= sel_next;
      ana_reg  <= ana_next;
      dig_reg  <= dig_next;
      dsel_reg <= dsel_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer. The go flag is the sequencer's own state, so it
  // can never disagree with what the converter is doing.

  acs_state_t state_reg, state_next;
  logic       go_req, ev_done, ev_refused;

  assign go_req = wr_ctrl & wb[CTL_GO];

  always_comb begin
    state_next = state_reg;
    ev_done    = 1'b0;
    ev_refused = 1'b0;
    case (state_reg)
      ACS_IDLE: begin
        if (go_req && on_next) begin
          state_next = ACS_START; // RULE5
        end else if (go_req) begin
          ev_refused = 1'b1; // RULE7
        end
      end
      ACS_START: begin
        if (!on_next) begin
          state_next = ACS_IDLE; // RULE7
        end else begin
          state_next = ACS_BUSY;
        end
      end
      ACS_BUSY: begin
        // Switching the converter off aborts and raises no completion.
        if (!on_next) begin
          state_next = ACS_IDLE; // RULE7
        end else if (adc_done) begin
          state_next = ACS_IDLE; // RULE6
          ev_done    = 1'b1;
        end
      end
      default: begin
        state_next = ACS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ACS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts. A new event beats a write-one-to-clear in the same cycle.

  logic [IRQ_W-1:0] stat_reg, stat_next;
  logic [IRQ_W-1:0] mask_reg, mask_next;
  logic [IRQ_W-1:0] ev;

  always_comb begin
    ev              = '0;
    ev[IRQ_DONE]    = ev_done;
    ev[IRQ_REFUSED] = ev_refused;
    stat_next       = stat_reg;
    mask_next       = mask_reg;
    if (wr_stat) begin
      stat_next = stat_reg & ~wb[IRQ_W-1:0];
    end
    stat_next = stat_next | ev;
    if (wr_mask) begin
      mask_next = wb[IRQ_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= IRQ_RST;
      mask_reg <= IRQ_RST;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data. Reads are built from next values so a read right behind a
  // write to the same register already returns the written value.

  logic [31:0] rdata_next;
  logic [7:0]  ctrl_view, abe_view, st_view;
  logic        go_view;

  assign go_view = (state_next != ACS_IDLE); // RULE5 RULE6

  always_comb begin
    ctrl_view = 8'h00; // RULE9
    ctrl_view[CTL_ON] = on_next;
    ctrl_view[CTL_GO] = go_view;
    ctrl_view[CTL_SEL_MSB:CTL_SEL_LSB] = sel_next;
    abe_view = 8'h00;
    abe_view[ABE_ANA] = ana_next;
    abe_view[ABE_DIG] = dig_next;
    abe_view[ABE_DSEL_MSB:ABE_DSEL_LSB] = dsel_next;
    st_view = 8'h00;
    st_view[ST_BUSY]    = go_view;
    st_view[ST_VALID]   = chan_valid(sel_next);
    st_view[ST_ANA_PIN] = ana_next & ~dig_next;
    st_view[ST_DIG_PIN] = dig_next;
    // The last read word stands until another read is taken.
    rdata_next = hrdata;
    if (take && !hwrite) begin
      if (haddr[7:0] == OFS_CTRL) begin
        rdata_next = 32'(ctrl_view);
      end else if (haddr[7:0] == OFS_ABE) begin
        rdata_next = 32'(abe_view);
      end else if (haddr[7:0] == OFS_IRQ_STAT) begin
        rdata_next = 32'(stat_next);
      end else if (haddr[7:0] == OFS_IRQ_MASK) begin
        rdata_next = 32'(mask_next);
      end else if (haddr[7:0] == OFS_STATUS) begin
        rdata_next = 32'(st_view);
      end else begin
        rdata_next = 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers.

  logic o_adc_next, o_apin_next, o_dpin_next, o_start_next, o_irq_next;

  always_comb begin
    o_dpin_next  = dig_next; // RULE11
    o_apin_next  = ana_next & ~dig_next; // RULE11
    o_adc_next   = ~ana_next; // RULE10
    o_start_next = (state_next == ACS_START); // RULE5
    o_irq_next   = |(stat_next & mask_next);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata         <= 32'h00000000;
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      converter_on   <= 1'b0;
      conv_start     <= 1'b0;
      amux_sel       <= SEL_RST;
      amux_sel_valid <= 1'b1;
      amux_to_adc    <= 1'b1;
      amux_to_pin    <= 1'b0;
      dmux_to_pin    <= 1'b0;
      dmux_sel       <= DSEL_RST;
      irq            <= 1'b0;
    end else begin
      hrdata         <= rdata_next;
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      converter_on   <= on_next; // RULE7
      conv_start     <= o_start_next;
      amux_sel       <= sel_next; // RULE8
      amux_sel_valid <= chan_valid(sel_next); // RULE3
      amux_to_adc    <= o_adc_next;
      amux_to_pin    <= o_apin_next;
      dmux_to_pin    <= o_dpin_next;
      dmux_sel       <= dsel_next;
      irq            <= o_irq_next;
    end
  end

endmodule : acs_top

`default_nettype wire

//--- dv/acs_assertions.sv
`default_nettype none
module acs_assertions
  import acs_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b0
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        converter_on,
  input wire logic        conv_start,
  input wire logic [4:0]  amux_sel,
  input wire logic        amux_sel_valid,
  input wire logic        amux_to_adc,
  input wire logic        amux_to_pin,
  input wire logic        dmux_to_pin
);
  ////////////////////////////////////////
  // Bit 0 marks a control write in its data phase, bit 1 a route write.
  logic       take;
  logic       lane;
  logic       vexp;
  logic [1:0] take_reg;
  logic [1:0] take_next;
  // Narrow writes count only when they carry byte lane zero.
  assign lane = !(hsize == 3'h0 && haddr[1:0] != 2'h0)
    && !(hsize == 3'h1 && haddr[1]);
  assign take = hsel && hready && htrans[1] && hwrite && lane;
  assign take_next = {take && haddr[7:0] == OFS_ABE,
                      take && haddr[7:0] == OFS_CTRL};
  assign vexp = amux_sel <= CH_INT_LAST
    || (amux_sel >= CH_INT2_FIRST && amux_sel <= CH_INT2_LAST)
    || (amux_sel >= CH_PIN_FIRST && (amux_sel <= CH_PIN_LAST || LARGE_PKG));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      take_reg <= 2'h0;
    end else begin
      take_reg <= take_next;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_sel_follow: assert property (
    take_reg[0] |=> amux_sel == $past(hwdata[6:2])) else $error("sel lost");
  a_on_follow: assert property (
    take_reg[0] |=> converter_on == $past(hwdata[0])) else $error("on lost");
  a_sel_hold: assert property (
    !take_reg[0] |=> $stable(amux_sel)) else $error("sel moved");
  a_start_pulse: assert property (
    conv_start |=> !conv_start) else $error("start too long");
  a_start_cause: assert property (
    conv_start |-> $past(take_reg[0]) && $past(hwdata[1]) && converter_on)
    else $error("start without go");
  a_route_write: assert property (
    take_reg[1] |=> dmux_to_pin == $past(hwdata[7])
      && amux_to_adc == !$past(hwdata[0])) else $error("route lost");
  a_route_pin: assert property (
    amux_to_pin == (!amux_to_adc && !dmux_to_pin)) else $error("pin owner");
  a_sel_valid: assert property (
    amux_sel_valid == vexp) else $error("valid flag wrong");
  c_start: cover property (conv_start);
  c_dig_wins: cover property (dmux_to_pin && !amux_to_adc);
  c_bad_code: cover property (!amux_sel_valid);
endmodule : acs_assertions

bind acs_top acs_assertions #(.LARGE_PKG(LARGE_PKG)) acs_assertions_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .converter_on, .conv_start, .amux_sel, .amux_sel_valid, .amux_to_adc,
  .amux_to_pin, .dmux_to_pin);
`default_nettype wire

//--- dv/acs_top_tb.sv
`default_nettype none
module acs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import acs_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        adc_done = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [4:0]  amux_sel;
  logic [2:0]  dmux_sel;
  logic        hreadyout, hresp, converter_on, conv_start, amux_sel_valid;
  logic        amux_to_adc, amux_to_pin, dmux_to_pin, irq;
  int          err_count = 0;
  int          num_checks = 0;
  always #25 hclk = ~hclk;
  acs_top acs_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .adc_done, .converter_on, .conv_start, .amux_sel, .amux_sel_valid,
    .amux_to_adc, .amux_to_pin, .dmux_to_pin, .dmux_sel, .irq);
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One idle edge first, so htrans is never lowered and raised at once.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk("hresp", 32'h0, hresp);
  endtask : rdc
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial begin
    #200000;
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    chk("pins", 32'h18, {amux_to_adc, amux_sel_valid, converter_on,
        dmux_to_pin, irq});
    rdc("ctrl", OFS_CTRL, 32'h0);
    rdc("status", OFS_STATUS, 32'h2);
    $display("reset test done");
    for (int c = 0; c < 32; c++) begin
      xfer(1'b1, OFS_CTRL, {24'h0, 1'b1, c[4:0], 2'b01});
      rdc("ctrl", OFS_CTRL, {25'h0, c[4:0], 2'b01});
      chk("amux_sel", c, amux_sel);
      chk("valid", c <= 7 || (c >= 10 && c <= 16) || (c >= 24 && c <= 28),
          amux_sel_valid);
    end
    $display("selector test done");
    xfer(1'b1, OFS_IRQ_MASK, 32'h1);
    xfer(1'b1, OFS_CTRL, 32'h0D);
    xfer(1'b1, OFS_CTRL, 32'h0F);
    #1 chk("conv_start", 32'h1, conv_start);
    rdc("busy", OFS_CTRL, 32'h0F);
    adc_done <= 1'b1;
    @(posedge hclk);
    adc_done <= 1'b0;
    rdc("done", OFS_CTRL, 32'h0D);
    chk("irq", 32'h1, irq);
    xfer(1'b1, OFS_IRQ_STAT, 32'h1);
    rdc("stat", OFS_IRQ_STAT, 32'h0);
    chk("irq", 32'h0, irq);
    xfer(1'b1, OFS_CTRL, 32'h02);
    #1 chk("conv_start", 32'h0, conv_start);
    rdc("refused", OFS_IRQ_STAT, 32'h2);
    chk("irq", 32'h0, irq);
    xfer(1'b1, OFS_IRQ_MASK, 32'h3);
    #1 chk("irq", 32'h1, irq);
    xfer(1'b1, OFS_IRQ_STAT, 32'h3);
    xfer(1'b1, OFS_CTRL, 32'h03);
    xfer(1'b1, OFS_CTRL, 32'h00);
    rdc("abort", OFS_CTRL, 32'h0);
    rdc("stat", OFS_IRQ_STAT, 32'h0);
    chk("on", 32'h0, converter_on);
    $display("conversion test done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, OFS_ABE, {24'h0, i[1], 6'h0, i[0]});
      rdc("abe", OFS_ABE, {24'h0, i[1], 6'h0, i[0]});
      chk("route", {!i[0], i[0] && !i[1], i[1]},
          {amux_to_adc, amux_to_pin, dmux_to_pin});
    end
    xfer(1'b1, OFS_ABE, 32'h50);
    rdc("abe", OFS_ABE, 32'h50);
    chk("dmux_sel", 32'h5, dmux_sel);
    xfer(1'b1, 8'h20, 32'hFF);
    rdc("unmapped", 8'h20, 32'h0);
    $display("route test done");
    wrap_up;
  end
endmodule : acs_top_tb
`default_nettype wire
